// [sarpr_pkg.sv]
/*
  Shared constants and types of the parallel-readout converter model.
  Assumes a single 200 MHz clock, mclk, on both ends.
*/
package sarpr_pkg;
  // ===========================================================
  // Clock and times
  localparam int CLK_PERIOD_PS    = 5000;
  localparam int TRIG_LOW_NS      = 20;
  localparam int CONV_TIME_NS     = 610;
  localparam int QUIET_BEFORE_NS  = 100;
  localparam int QUIET_AFTER_NS   = 40;
  localparam int RESET_LOW_NS     = 20;
  localparam int RESET_RECOVER_NS = 20;
  localparam int ACQ_TIME_NS      = 150;
  // Least times round up, longest times round down
  localparam int TRIG_LOW_CYC     = (TRIG_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CONV_CYC         = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int QUIET_BEFORE_CYC = (QUIET_BEFORE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int QUIET_AFTER_CYC  = (QUIET_AFTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RESET_LOW_CYC    = (RESET_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RECOVER_CYC      = (RESET_RECOVER_NS * 1000) / CLK_PERIOD_PS;
  localparam int ACQ_CYC          = (ACQ_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WARMUP_CONVS     = 3;
  // Read dwell must outlast both ends' synchroniser and register latency
  localparam int READ_HOLD_CYC    = 6;
  // ===========================================================
  // Data layout
  localparam int RES_W            = 16;
  localparam int BYTE_W           = 8;
  localparam logic [15:0] RES_RESET  = 16'h0000;
  localparam logic [7:0]  LOW_FILL   = 8'hFF;
  localparam int FIFO_DEPTH       = 16;
  localparam int CNT_W            = 8;
  // ===========================================================
  // State types
  typedef enum logic [1:0] {
    SARPR_RECOVER = 2'b00,
    SARPR_SAMPLE  = 2'b01,
    SARPR_CONVERT = 2'b11,
    SARPR_DONE    = 2'b10
  } sarpr_dev_e;
  typedef enum logic [2:0] {
    SARPR_H_IDLE  = 3'b000,
    SARPR_H_TRIG  = 3'b001,
    SARPR_H_WAIT  = 3'b011,
    SARPR_H_RDHI  = 3'b010,
    SARPR_H_RDLO  = 3'b110,
    SARPR_H_PUSH  = 3'b111,
    SARPR_H_RST   = 3'b101
  } sarpr_host_e;
endpackage : sarpr_pkg

// [sarpr_if.sv]
/*
  Pin bundle between the converter end and the host end.
  Assumes the testbench ties both modports to the same instance.
*/
`timescale 1ns/1ps
interface sarpr_if;
  logic        conversion_trigger_n;
  logic        cs_n;
  logic        rd_n;
  logic        byte_sel;
  logic        reset_n;
  logic        busy;
  logic [15:0] output_bus_o;
  logic        output_bus_oe;
  logic [15:0] output_bus;
  // Bus resolves to its driven value, else floats high for the model
  assign output_bus = output_bus_oe ? output_bus_o : 16'hFFFF;
  modport dev (
    input  conversion_trigger_n, cs_n, rd_n, byte_sel, reset_n,
    output busy, output_bus_o, output_bus_oe
  );
  modport host (
    output conversion_trigger_n, cs_n, rd_n, byte_sel, reset_n,
    input  busy, output_bus, output_bus_oe
  );
endinterface : sarpr_if

// [sarpr_fifo.sv]
/*
  Flip-flop FIFO with valid/ready on both sides.
  Assumes one clock and an active-high asynchronous reset.
*/
`timescale 1ns/1ps
module sarpr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;
  assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop)  rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule : sarpr_fifo

// [sarpr_dev.sv]
/*
  Converter end: sample/hold, conversion timing, busy and parallel readout.
  Assumes pins arrive asynchronously and are synchronised here; the analog
  value is a digital sample word given on analog_code.
*/
`timescale 1ns/1ps
// ===========================================================
// Two-flop synchroniser for one pin
module sarpr_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      synced
);
  logic meta;
  // Only the second flop is read, so metastability stays inside
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta   <= RESET_VAL;
      synced <= RESET_VAL;
    end else begin
      meta   <= pin;
      synced <= meta;
    end
  end
endmodule : sarpr_sync
// ===========================================================
// Falling-edge detector on a synchronised, idle-high level
module sarpr_fall (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic level,
  output logic      fell
);
  logic last;
  // Resets to the idle level so no false edge follows reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      last <= 1'b1;
    end else begin
      last <= level;
    end
  end
  assign fell = last && !level;
endmodule : sarpr_fall
// ===========================================================
// Converter end
module sarpr_dev #(
  parameter int CONV_CYCLES = sarpr_pkg::CONV_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  sarpr_if.dev             pins,
  input  wire logic [15:0] analog_code,
  output logic             sampling,
  output logic [15:0]      held_code
);
  import sarpr_pkg::*;
  if (CONV_CYCLES < 2 || CONV_CYCLES > 255) begin : g_bad_conv_cycles
    $error("CONV_CYCLES out of range");
  end
  // ===========================================================
  // Pin synchronisers
  logic trig_sync;
  logic cs_sync;
  logic rd_sync;
  logic byte_sync;
  logic rstn_sync;
  sarpr_sync #(.RESET_VAL(1'b1)) i_sarpr_sync_trig (
    .mclk   (mclk),
    .rst    (rst),
    .pin    (pins.conversion_trigger_n),
    .synced (trig_sync)
  );
  sarpr_sync #(.RESET_VAL(1'b1)) i_sarpr_sync_cs (
    .mclk   (mclk),
    .rst    (rst),
    .pin    (pins.cs_n),
    .synced (cs_sync)
  );
  sarpr_sync #(.RESET_VAL(1'b1)) i_sarpr_sync_rd (
    .mclk   (mclk),
    .rst    (rst),
    .pin    (pins.rd_n),
    .synced (rd_sync)
  );
  sarpr_sync #(.RESET_VAL(1'b0)) i_sarpr_sync_byte (
    .mclk   (mclk),
    .rst    (rst),
    .pin    (pins.byte_sel),
    .synced (byte_sync)
  );
  sarpr_sync #(.RESET_VAL(1'b0)) i_sarpr_sync_rstn (
    .mclk   (mclk),
    .rst    (rst),
    .pin    (pins.reset_n),
    .synced (rstn_sync)
  );
  // Reset pin clears directly, without the clock
  logic dev_rst;
  assign dev_rst = rst || !pins.reset_n;
  logic trig_fall;
  logic cs_fall;
  sarpr_fall i_sarpr_fall_trig (
    .mclk  (mclk),
    .rst   (dev_rst),
    .level (trig_sync),
    .fell  (trig_fall)
  );
  sarpr_fall i_sarpr_fall_cs (
    .mclk  (mclk),
    .rst   (dev_rst),
    .level (cs_sync),
    .fell  (cs_fall)
  );
  // ===========================================================
  // Conversion state
  sarpr_dev_e      state;
  logic [CNT_W-1:0] cnt;
  logic [15:0]     result;
  always_ff @(posedge mclk or posedge dev_rst) begin
    if (dev_rst) begin
      state     <= SARPR_RECOVER;
      cnt       <= '0;
      held_code <= RES_RESET;
      result    <= RES_RESET;
    end else begin
      unique case (state)
        SARPR_RECOVER: begin
          if (!rstn_sync) begin
            cnt <= '0;
          end else if (cnt >= CNT_W'(RECOVER_CYC - 1)) begin
            cnt   <= '0;
            state <= SARPR_SAMPLE;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        // Hold on trigger fall with chip select low
        SARPR_SAMPLE: begin
          if (trig_fall && !cs_sync) begin
            held_code <= analog_code;
            cnt       <= '0;
            state     <= SARPR_CONVERT;
          end
        end
        SARPR_CONVERT: begin
          if (cnt == CNT_W'(CONV_CYCLES - 1)) begin
            result <= held_code;
            state  <= SARPR_DONE;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        // Resample on busy fall or later cs fall
        SARPR_DONE: begin
          if (!cs_sync || cs_fall) begin
            state <= SARPR_SAMPLE;
          end
        end
      endcase
    end
  end
  assign pins.busy = (state == SARPR_CONVERT);
  assign sampling  = (state == SARPR_SAMPLE);
  // ===========================================================
  // Readout
  logic [15:0] bus_q;
  logic        oe_q;
  always_ff @(posedge mclk or posedge dev_rst) begin
    if (dev_rst) begin
      bus_q <= RES_RESET;
      oe_q  <= 1'b0;
    end else begin
      // Drive only with cs and rd low
      oe_q <= !cs_sync && !rd_sync;
      // Word or low byte on top lines
      bus_q <= byte_sync ? {result[BYTE_W-1:0], LOW_FILL} : result;
    end
  end
  assign pins.output_bus_o  = bus_q;
  assign pins.output_bus_oe = oe_q;
endmodule : sarpr_dev

// [sarpr_host.sv]
/*
  Host end: resets, triggers conversions, reads the result as two bytes
  on the upper lines, and queues words into a FIFO.
  Assumes the converter end answers within its conversion time.
*/
`timescale 1ns/1ps
module sarpr_host #(
  parameter int DEPTH = sarpr_pkg::FIFO_DEPTH
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  sarpr_if.host            pins,
  input  wire logic        start,
  output logic             ready,
  output logic [15:0]      word_data,
  output logic             word_valid,
  input  wire logic        word_ready
);
  import sarpr_pkg::*;
  logic [1:0]        busy_s;
  logic [1:0]        bus_hi_s [BYTE_W];
  logic              busy_q;
  sarpr_host_e       state;
  logic [CNT_W-1:0]  cnt;
  logic [1:0]        warm;
  logic [7:0]        hi_byte;
  logic [15:0]       push_data;
  logic              push_valid;
  logic              push_ready;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy_s <= 2'b00;
      busy_q <= 1'b0;
      for (int i = 0; i < BYTE_W; i++) bus_hi_s[i] <= 2'b00;
    end else begin
      busy_s <= {busy_s[0], pins.busy};
      busy_q <= busy_s[1];
      for (int i = 0; i < BYTE_W; i++) begin
        bus_hi_s[i] <= {bus_hi_s[i][0], pins.output_bus[BYTE_W+i]};
      end
    end
  end
  logic [7:0] bus_hi;
  always_comb begin
    bus_hi = '0;
    for (int i = 0; i < BYTE_W; i++) bus_hi[i] = bus_hi_s[i][1];
  end
  logic busy_fall;
  assign busy_fall = busy_q && !busy_s[1];
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state                     <= SARPR_H_RST;
      cnt                       <= '0;
      warm                      <= '0;
      hi_byte                   <= '0;
      push_data                 <= '0;
      push_valid                <= 1'b0;
      pins.conversion_trigger_n <= 1'b1;
      pins.cs_n                 <= 1'b1;
      pins.rd_n                 <= 1'b1;
      pins.byte_sel             <= 1'b0;
      pins.reset_n              <= 1'b0;
    end else begin
      if (push_valid && push_ready) push_valid <= 1'b0;
      unique case (state)
        SARPR_H_RST: begin
          cnt <= cnt + 1'b1;
          if (cnt == CNT_W'(RESET_LOW_CYC)) pins.reset_n <= 1'b1;
          if (cnt == CNT_W'(RESET_LOW_CYC + ACQ_CYC)) begin
            cnt   <= '0;
            state <= SARPR_H_IDLE;
          end
        end
        // Chip select low, quiet before trigger
        SARPR_H_IDLE: begin
          pins.cs_n <= 1'b0;
          if (cnt < CNT_W'(QUIET_BEFORE_CYC)) begin
            cnt <= cnt + 1'b1;
          end else if ((start || warm != 2'(WARMUP_CONVS)) && !push_valid) begin
            cnt                       <= '0;
            pins.conversion_trigger_n <= 1'b0;
            state                     <= SARPR_H_TRIG;
          end
        end
        // Hold trigger low the least time
        SARPR_H_TRIG: begin
          cnt <= cnt + 1'b1;
          if (cnt == CNT_W'(TRIG_LOW_CYC - 1)) pins.conversion_trigger_n <= 1'b1;
          if (cnt >= CNT_W'(QUIET_AFTER_CYC) && cnt >= CNT_W'(TRIG_LOW_CYC)) begin
            state <= SARPR_H_WAIT;
          end
        end
        // Two reads, rd held low throughout
        SARPR_H_WAIT: begin
          if (busy_fall) begin
            pins.rd_n     <= 1'b0;
            pins.byte_sel <= 1'b0;
            cnt           <= '0;
            state         <= SARPR_H_RDHI;
          end
        end
        SARPR_H_RDHI: begin
          cnt <= cnt + 1'b1;
          if (cnt == CNT_W'(READ_HOLD_CYC)) begin
            hi_byte       <= bus_hi;
            pins.byte_sel <= 1'b1;
            cnt           <= '0;
            state         <= SARPR_H_RDLO;
          end
        end
        SARPR_H_RDLO: begin
          cnt <= cnt + 1'b1;
          if (cnt == CNT_W'(READ_HOLD_CYC)) begin
            push_data     <= {hi_byte, bus_hi};
            pins.rd_n     <= 1'b1;
            pins.byte_sel <= 1'b0;
            cnt           <= '0;
            state         <= SARPR_H_PUSH;
          end
        end
        // Warm-up results are discarded
        SARPR_H_PUSH: begin
          if (warm != 2'(WARMUP_CONVS)) begin
            warm <= warm + 1'b1;
          end else begin
            push_valid <= 1'b1;
          end
          state <= SARPR_H_IDLE;
        end
        default: state <= SARPR_H_RST;
      endcase
    end
  end
  assign ready = (state == SARPR_H_IDLE) && (warm == 2'(WARMUP_CONVS)) && !push_valid &&
                 (cnt >= CNT_W'(QUIET_BEFORE_CYC));
  sarpr_fifo #(.WIDTH(RES_W), .DEPTH(DEPTH)) i_sarpr_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_data   (push_data),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .out_data  (word_data),
    .out_valid (word_valid),
    .out_ready (word_ready)
  );
endmodule : sarpr_host

// [sarpr_asserts.sv]
/*
  Checker of the pin bundle between the converter end and the host end.
  Assumes it is instantiated beside the interface, fed by its signals.
*/
`timescale 1ns/1ps
module sarpr_asserts #(
  parameter int CONV_CYCLES = sarpr_pkg::CONV_CYC
) (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        conversion_trigger_n,
  input wire logic        cs_n,
  input wire logic        rd_n,
  input wire logic        byte_sel,
  input wire logic        reset_n,
  input wire logic        busy,
  input wire logic [15:0] output_bus_o,
  input wire logic        output_bus_oe
);
  // ===========================================================
  // Busy length counter
  logic [15:0] busy_cnt;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy_cnt <= 16'h0000;
    end else begin
      busy_cnt <= busy ? busy_cnt + 16'h0001 : 16'h0000;
    end
  end
  // Cycles since the bus was last read, saturating
  logic [7:0] quiet_cnt;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      quiet_cnt <= 8'h00;
    end else if (!cs_n && !rd_n) begin
      quiet_cnt <= 8'h00;
    end else if (quiet_cnt != 8'hFF) begin
      quiet_cnt <= quiet_cnt + 8'h01;
    end
  end
  // ===========================================================
  // Properties
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Pins reach the bus logic through a synchroniser, so allow settling
  sequence s_read_on;
    (!cs_n && !rd_n && reset_n) [*5];
  endsequence
  sequence s_read_off;
    (cs_n || rd_n) [*4];
  endsequence
  property p_bus_drive;
    s_read_on |-> output_bus_oe;
  endproperty
  property p_bus_float;
    s_read_off |-> !output_bus_oe;
  endproperty
  property p_low_fill;
    (output_bus_oe && byte_sel) [*5] |-> output_bus_o[7:0] == 8'hFF;
  endproperty
  property p_word_stable;
    (output_bus_oe && !byte_sel) [*4] |-> $stable(output_bus_o);
  endproperty
  property p_busy_cause;
    $rose(busy) |-> !cs_n && (!$past(conversion_trigger_n, 2) ||
      !$past(conversion_trigger_n, 3) || !$past(conversion_trigger_n, 4));
  endproperty
  property p_busy_hold;
    $rose(busy) |-> (busy || !reset_n) [*8];
  endproperty
  property p_conv_len;
    $fell(busy) && reset_n |-> busy_cnt == CONV_CYCLES;
  endproperty
  property p_reset_clear;
    !reset_n |-> !busy && !output_bus_oe && output_bus_o == 16'h0000;
  endproperty
  property p_recover;
    $rose(reset_n) |-> !busy [*4];
  endproperty
  sequence s_trig_fall;
    $fell(conversion_trigger_n);
  endsequence
  property p_trig_cs;
    s_trig_fall |-> !cs_n;
  endproperty
  property p_trig_width;
    s_trig_fall |-> (!conversion_trigger_n) [*4];
  endproperty
  property p_quiet_before;
    s_trig_fall |-> quiet_cnt >= sarpr_pkg::QUIET_BEFORE_CYC;
  endproperty
  property p_quiet_after;
    s_trig_fall |-> (cs_n || rd_n) [*8];
  endproperty
  property p_byte_in_read;
    $rose(byte_sel) |-> !cs_n && !rd_n;
  endproperty
  property p_read_after_busy;
    $fell(rd_n) |-> !busy;
  endproperty
  a_bus_drive: assert property (p_bus_drive)
    else $error("bus not driven during read");
  a_bus_float: assert property (p_bus_float)
    else $error("bus driven outside read");
  a_low_fill: assert property (p_low_fill)
    else $error("lower lines not all ones in byte mode");
  a_word_stable: assert property (p_word_stable)
    else $error("word changed during read");
  a_busy_cause: assert property (p_busy_cause)
    else $error("busy rose without trigger");
  a_busy_hold: assert property (p_busy_hold)
    else $error("busy dropped early");
  a_conv_len: assert property (p_conv_len)
    else $error("conversion length wrong");
  a_reset_clear: assert property (p_reset_clear)
    else $error("reset did not clear outputs");
  a_recover: assert property (p_recover)
    else $error("busy during recovery");
  a_trig_cs: assert property (p_trig_cs)
    else $error("trigger fell with chip select high");
  a_trig_width: assert property (p_trig_width)
    else $error("trigger low pulse too short");
  a_quiet_before: assert property (p_quiet_before)
    else $error("read too close before trigger");
  a_quiet_after: assert property (p_quiet_after)
    else $error("read too close after trigger");
  a_byte_in_read: assert property (p_byte_in_read)
    else $error("byte select raised outside a read");
  a_read_after_busy: assert property (p_read_after_busy)
    else $error("read started while busy");
endmodule : sarpr_asserts

// [tb_sar_adc_parallel_readout.sv]
/*
  Testbench: host end and converter end joined by the pin bundle.
  Assumes the host runs its own reset and warm-up before raising ready.
*/
`timescale 1ns/1ps
`define CHECK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tb_sar_adc_parallel_readout;
  import sarpr_pkg::*;
  // Short conversion keeps the run brief
  localparam int SHORT_CONV = 10;
  logic        mclk        = 1'b0;
  logic        rst         = 1'b1;
  logic        start       = 1'b0;
  logic        word_ready  = 1'b0;
  logic [15:0] analog_code = 16'h0000;
  logic        ready;
  logic        word_valid;
  logic        sampling;
  logic [15:0] word_data;
  logic [15:0] held_code;
  int          errors      = 0;
  int          comparisons = 0;
  int          n;
  logic [15:0] codes [5]   = '{16'h0000, 16'h8000, 16'h7FFF, 16'hFFFF, 16'hA55A};
  always #2.5 mclk = ~mclk;
  sarpr_if i_sarpr_if ();
  sarpr_dev #(.CONV_CYCLES(SHORT_CONV)) i_sarpr_dev (.mclk(mclk), .rst(rst),
    .pins(i_sarpr_if), .analog_code(analog_code), .sampling(sampling),
    .held_code(held_code));
  sarpr_host #(.DEPTH(FIFO_DEPTH)) i_sarpr_host (.mclk(mclk), .rst(rst),
    .pins(i_sarpr_if), .start(start), .ready(ready), .word_data(word_data),
    .word_valid(word_valid), .word_ready(word_ready));
  sarpr_asserts #(.CONV_CYCLES(SHORT_CONV)) i_sarpr_asserts (.mclk(mclk), .rst(rst),
    .conversion_trigger_n(i_sarpr_if.conversion_trigger_n), .cs_n(i_sarpr_if.cs_n),
    .rd_n(i_sarpr_if.rd_n), .byte_sel(i_sarpr_if.byte_sel),
    .reset_n(i_sarpr_if.reset_n), .busy(i_sarpr_if.busy),
    .output_bus_o(i_sarpr_if.output_bus_o), .output_bus_oe(i_sarpr_if.output_bus_oe));
  // ===========================================================
  // Tasks
  task automatic convert(input logic [15:0] code);
    int k;
    k = 0;
    analog_code <= code;
    start <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (ready !== 1'b1 && k < 2000);
    start <= 1'b0;
    `CHECK("ready", 1'b1, ready)
    // Hold the sample word until the converter has taken it
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (i_sarpr_if.busy !== 1'b1 && k < 64);
    `CHECK("busy", 1'b1, i_sarpr_if.busy)
    `CHECK("sampling", 1'b0, sampling)
    @(posedge mclk);
  endtask : convert
  task automatic pop(input logic [15:0] exp);
    int k;
    k = 0;
    word_ready <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (word_valid !== 1'b1 && k < 2000);
    word_ready <= 1'b0;
    `CHECK("word_data", exp, word_data)
    @(posedge mclk);
  endtask : pop
  task automatic give_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict
  // ===========================================================
  // Tests
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      convert(codes[i]);
      pop(codes[i]);
      `CHECK("held_code", codes[i], held_code)
      `CHECK("resample", 1'b1, sampling)
    end
    repeat (8) @(posedge mclk);
    `CHECK("idle bus", 16'hFFFF, i_sarpr_if.output_bus)
    $display("test codes done");
    // Stall the reader over FIFO_DEPTH conversions, peaking one short of full, then drain in order
    for (int i = 0; i < FIFO_DEPTH; i++) convert(16'h0100 + 16'(i));
    for (int i = 0; i < FIFO_DEPTH; i++) pop(16'h0100 + 16'(i));
    `CHECK("drained", 1'b0, word_valid)
    $display("test buffer done");
    convert(16'h1234);
    n = 0;
    while (i_sarpr_if.busy !== 1'b1 && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    `CHECK("busy abort", 1'b0, i_sarpr_if.busy)
    convert(16'h4321);
    pop(16'h4321);
    `CHECK("no stale", 1'b0, word_valid)
    $display("test reset done");
    give_verdict();
  end
  // Tests need about 1600 cycles; nearly forty times that marks a hang
  initial begin
    repeat (60000) @(posedge mclk);
    errors++;
    give_verdict();
  end
endmodule : tb_sar_adc_parallel_readout
